// *** hdl/mrsl_defs.svh ***
// constants of the modbus rtu slave serial front end
// assumes a 50 mhz system clock; included by bare name
`ifndef MRSL_DEFS_SVH
`define MRSL_DEFS_SVH

// ==========================================================================
// clock and times
`define MRSL_CLK_HZ        50000000
`define MRSL_RESTORE_S     5
`define MRSL_RESTORE_CYC   (`MRSL_CLK_HZ * `MRSL_RESTORE_S)

// ==========================================================================
// serial_line_setup holding register and its fields
`define MRSL_SETUP_ADDR    16'h0111
`define MRSL_SETUP_RST     16'h0009
`define MRSL_SPD_LSB       0
`define MRSL_SPD_MSB       2
`define MRSL_PAR_BIT       3

// ==========================================================================
// speed codes and bit periods in clock cycles (rounded down)
`define MRSL_SPD_9600      3'h0
`define MRSL_SPD_19200     3'h1
`define MRSL_SPD_38400     3'h2
`define MRSL_SPD_57600     3'h3
`define MRSL_DIV_9600      13'(`MRSL_CLK_HZ / 9600)
`define MRSL_DIV_19200     13'(`MRSL_CLK_HZ / 19200)
`define MRSL_DIV_38400     13'(`MRSL_CLK_HZ / 38400)
`define MRSL_DIV_57600     13'(`MRSL_CLK_HZ / 57600)
`define MRSL_DIV_115200    13'(`MRSL_CLK_HZ / 115200)

// ==========================================================================
// station addresses and frame silence
`define MRSL_STATION_RST   8'h01
`define MRSL_STATION_MIN   8'h01
`define MRSL_STATION_MAX   8'hf7
`define MRSL_BCAST_ADDR    8'h00
`define MRSL_GAP_BITS      6'h23
`define MRSL_BITS_PAR      4'ha
`define MRSL_BITS_NOPAR    4'h9

`endif

// *** hdl/mrsl_link.sv ***
// serial front end of a modbus rtu slave: framing, address filter, reply
// driver, line passthrough and factory restore.
// assumes one 50 mhz clock, synchronous reset, and an on-board controller
// that decodes queries and writes the setup holding register through here.
`timescale 1ns/1ps
`include "mrsl_defs.svh"

module mrsl_link
    import mrsl_pkg::*;
#(
    parameter int unsigned RESTORE_CYC = `MRSL_RESTORE_CYC
)
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        rs485_rx_in,
    input  wire logic        uart_rx_in,
    input  wire logic        factory_restore_in,
    input  wire logic        setup_wr_in,
    input  wire logic [15:0] setup_data_in,
    input  wire logic        station_wr_in,
    input  wire logic [7:0]  station_data_in,
    input  wire logic        tx_valid_in,
    input  wire logic [7:0]  tx_data_in,
    output logic             tx_ready_out,
    output logic             rs485_tx_out,
    output logic             rs485_de_out,
    output logic             uart_tx_out,
    output logic             rx_valid_out,
    output logic             rx_sof_out,
    output logic             rx_perr_out,
    output logic [7:0]       rx_data_out,
    output logic [15:0]      setup_out,
    output logic [7:0]       station_out
);

    // ======================================================================
    // state registers
    mrsl_state_t q;
    mrsl_state_t n;

    // bit period for the selected speed; unknown codes fall back to 115200
    function automatic logic [12:0] bit_div(input logic [2:0] code);
        unique case (code)
            `MRSL_SPD_9600:  bit_div = `MRSL_DIV_9600;
            `MRSL_SPD_19200: bit_div = `MRSL_DIV_19200;
            `MRSL_SPD_38400: bit_div = `MRSL_DIV_38400;
            `MRSL_SPD_57600: bit_div = `MRSL_DIV_57600;
            default:         bit_div = `MRSL_DIV_115200;
        endcase
    endfunction

    logic [12:0] div;
    logic        par;
    logic        line;
    logic [3:0]  nbits;
    logic [9:0]  sh;
    logic [7:0]  byte_v;

    // ======================================================================
    // next state
    always_comb
    begin
        n        = q;
        sh       = q.rx_sh;
        byte_v   = 8'h00;
        div      = bit_div(q.setup[`MRSL_SPD_MSB:`MRSL_SPD_LSB]);
        par      = q.setup[`MRSL_PAR_BIT];
        nbits    = par ? `MRSL_BITS_PAR : `MRSL_BITS_NOPAR;
        line     = q.rs_lv & q.ua_lv;  // both receivers share one data path
        n.rx_valid = 1'b0;
        n.rx_sof   = 1'b0;
        n.rx_perr  = 1'b0;

        // three-stage synchronisers, level taken once stages two and three agree
        n.rs_s = {q.rs_s[1:0], rs485_rx_in};
        n.ua_s = {q.ua_s[1:0], uart_rx_in};
        n.jp_s = {q.jp_s[1:0], factory_restore_in};
        if (q.rs_s[1] == q.rs_s[2])
            n.rs_lv = q.rs_s[2];
        if (q.ua_s[1] == q.ua_s[2])
            n.ua_lv = q.ua_s[2];
        if (q.jp_s[1] == q.jp_s[2])
            n.jp_lv = q.jp_s[2];

        // receiver: start edge, mid-bit sampling, lsb first
        unique case (q.rx_st)
            MRSL_RX_IDLE:
            begin
                if (q.tx_st == MRSL_TX_IDLE && !line)
                begin
                    n.rx_st    = MRSL_RX_RUN;
                    n.rx_cnt   = div >> 1;
                    n.rx_bit   = 4'h0;
                    n.gap_cnt  = 13'h0000;
                    n.gap_bits = 6'h00;
                end
            end
            MRSL_RX_RUN:
            begin
                if (q.rx_cnt != 13'h0000)
                    n.rx_cnt = q.rx_cnt - 13'h0001;
                else if (q.rx_bit == 4'h0)
                begin
                    n.rx_cnt = div;
                    n.rx_bit = 4'h1;
                    if (line)
                        n.rx_st = MRSL_RX_IDLE;  // glitch, not a start bit
                end
                else
                begin
                    n.rx_cnt = div;
                    n.rx_bit = q.rx_bit + 4'h1;
                    sh       = {line, q.rx_sh[9:1]};
                    n.rx_sh  = sh;
                    if (q.rx_bit == nbits)
                    begin
                        n.rx_st  = MRSL_RX_IDLE;
                        byte_v   = par ? sh[7:0] : sh[8:1];
                        n.rx_data = byte_v;
                        n.rx_perr = ~sh[9] | (par & ^sh[8:0]);
                        // first byte after silence carries the station address
                        if (q.frame_new)
                        begin
                            n.accept    = (byte_v == q.station) ||
                                          (byte_v == `MRSL_BCAST_ADDR);
                            n.bcast     = (byte_v == `MRSL_BCAST_ADDR);
                            n.frame_new = 1'b0;
                            n.rx_sof    = n.accept;
                        end
                        n.rx_valid = n.accept;
                    end
                end
            end
            default:
                n.rx_st = MRSL_RX_IDLE;
        endcase

        // silence of 35 bit periods, three and a half characters without parity, closes a frame
        if (q.rx_st == MRSL_RX_IDLE && n.rx_st == MRSL_RX_IDLE &&
            q.tx_st == MRSL_TX_IDLE && q.gap_bits != `MRSL_GAP_BITS)
        begin
            if (q.gap_cnt == div)
            begin
                n.gap_cnt  = 13'h0000;
                n.gap_bits = q.gap_bits + 6'h01;
                if (n.gap_bits == `MRSL_GAP_BITS)
                begin
                    n.frame_new = 1'b1;
                    n.fwd       = 1'b0;
                end
            end
            else
                n.gap_cnt = q.gap_cnt + 13'h0001;
        end

        // uart-side traffic owns the rs485 driver until its frame ends
        if (!q.ua_lv && q.tx_st == MRSL_TX_IDLE)
            n.fwd = 1'b1;

        // reply transmitter; requests after a broadcast or foreign frame drop
        unique case (q.tx_st)
            MRSL_TX_IDLE:
            begin
                if (tx_valid_in && q.tx_ready && q.accept && !q.bcast && line)
                begin
                    n.tx_st  = MRSL_TX_RUN;
                    n.tx_cnt = div;
                    n.tx_bit = nbits + 4'h1;  // start bit on top of the received count
                    n.tx_sh  = {1'b1, par ? ^tx_data_in : 1'b1, tx_data_in, 1'b0};
                    n.gap_cnt  = 13'h0000;
                    n.gap_bits = 6'h00;
                    n.frame_new = 1'b0;
                end
            end
            MRSL_TX_RUN:
            begin
                if (q.tx_cnt != 13'h0000)
                    n.tx_cnt = q.tx_cnt - 13'h0001;
                else
                begin
                    n.tx_cnt = div;
                    n.tx_sh  = {1'b1, q.tx_sh[10:1]};
                    n.tx_bit = q.tx_bit - 4'h1;
                    if (q.tx_bit == 4'h1)
                        n.tx_st = MRSL_TX_IDLE;
                end
            end
            default:
                n.tx_st = MRSL_TX_IDLE;
        endcase

        // setup writes wait for an idle line so no character changes speed
        if (setup_wr_in)
        begin
            n.pend   = setup_data_in;
            n.pend_v = 1'b1;
        end
        else if (q.pend_v && n.rx_st == MRSL_RX_IDLE && n.tx_st == MRSL_TX_IDLE)
        begin
            n.setup  = q.pend;
            n.pend_v = 1'b0;
        end

        // out-of-range station addresses are refused
        if (station_wr_in && station_data_in >= `MRSL_STATION_MIN &&
            station_data_in <= `MRSL_STATION_MAX)
            n.station = station_data_in;

        // factory restore once the jumper has stood for the full time
        if (!q.jp_lv)
            n.rst_cnt = 28'h0000000;
        else if (!q.restored)
        begin
            n.rst_cnt = q.rst_cnt + 28'h0000001;
            if (q.rst_cnt == 28'(RESTORE_CYC - 1))
            begin
                n.station  = `MRSL_STATION_RST;
                n.setup    = `MRSL_SETUP_RST;
                n.pend_v   = 1'b0;
                n.restored = 1'b1;
            end
        end

        // pins: own reply on both sides, otherwise mirror the far side
        n.rs485_tx = (n.tx_st == MRSL_TX_RUN) ? n.tx_sh[0] : n.ua_lv;
        n.uart_tx  = (n.tx_st == MRSL_TX_RUN) ? n.tx_sh[0] : n.rs_lv;
        n.rs485_de = (n.tx_st == MRSL_TX_RUN) || n.fwd;
        n.tx_ready = (n.tx_st == MRSL_TX_IDLE) && (n.rx_st == MRSL_RX_IDLE) &&
                     n.frame_new;

        // synchronous reset to the default line setup
        if (sys_rst_in)
        begin
            n          = '0;
            n.rs_s     = 3'h7;
            n.ua_s     = 3'h7;
            n.rs_lv    = 1'b1;
            n.ua_lv    = 1'b1;
            n.setup    = `MRSL_SETUP_RST;
            n.station  = `MRSL_STATION_RST;
            n.rx_st    = MRSL_RX_IDLE;
            n.tx_st    = MRSL_TX_IDLE;
            n.rs485_tx = 1'b1;
            n.uart_tx  = 1'b1;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk_in)
    begin
        q <= n;
    end

    // outputs straight from flops
    assign tx_ready_out = q.tx_ready;
    assign rs485_tx_out = q.rs485_tx;
    assign rs485_de_out = q.rs485_de;
    assign uart_tx_out  = q.uart_tx;
    assign rx_valid_out = q.rx_valid;
    assign rx_sof_out   = q.rx_sof;
    assign rx_perr_out  = q.rx_perr;
    assign rx_data_out  = q.rx_data;
    assign setup_out    = q.setup;
    assign station_out  = q.station;

    // ======================================================================
    // checks
    property p_rst_default;
        @(posedge clk_in) $past(sys_rst_in) && !sys_rst_in |->
            q.setup == `MRSL_SETUP_RST && q.station == `MRSL_STATION_RST;
    endproperty
    a_rst_default: assert property (p_rst_default) else $error("bad reset setup");

    property p_setup_idle;
        @(posedge clk_in) disable iff (sys_rst_in) $changed(q.setup) && !$rose(q.restored)
            |-> $past(q.pend_v) && q.setup == $past(q.pend);
    endproperty
    a_setup_idle: assert property (p_setup_idle) else $error("setup not from write");

    property p_restore;
        @(posedge clk_in) disable iff (sys_rst_in) $rose(q.restored) |->
            q.station == `MRSL_STATION_RST && q.setup == `MRSL_SETUP_RST && $past(q.jp_lv);
    endproperty
    a_restore: assert property (p_restore) else $error("restore values wrong");

    property p_station_range;
        @(posedge clk_in) disable iff (sys_rst_in)
            q.station >= `MRSL_STATION_MIN && q.station <= `MRSL_STATION_MAX;
    endproperty
    a_station_range: assert property (p_station_range) else $error("station range");

    property p_bcast_quiet;
        @(posedge clk_in) disable iff (sys_rst_in) q.bcast && q.tx_st == MRSL_TX_IDLE
            |=> q.tx_st == MRSL_TX_IDLE;
    endproperty
    a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast answered");

    property p_one_talker;
        @(posedge clk_in) disable iff (sys_rst_in)
            q.tx_st == MRSL_TX_RUN |-> q.rx_st == MRSL_RX_IDLE;
    endproperty
    a_one_talker: assert property (p_one_talker) else $error("tx during rx");

    property p_de_own;
        @(posedge clk_in) disable iff (sys_rst_in)
            $rose(q.rs485_de) |-> q.tx_st == MRSL_TX_RUN || !$past(q.ua_lv);
    endproperty
    a_de_own: assert property (p_de_own) else $error("driver enabled idle");

    property p_mirror;
        @(posedge clk_in) disable iff (sys_rst_in)
            q.tx_st == MRSL_TX_IDLE |-> q.uart_tx == q.rs_lv && q.rs485_tx == q.ua_lv;
    endproperty
    a_mirror: assert property (p_mirror) else $error("passthrough broken");

    property p_filter;
        @(posedge clk_in) disable iff (sys_rst_in) q.rx_valid |-> q.accept &&
            (!q.rx_sof || q.rx_data == q.station || q.rx_data == `MRSL_BCAST_ADDR);
    endproperty
    a_filter: assert property (p_filter) else $error("foreign byte passed");

endmodule

// *** hdl/mrsl_pkg.sv ***
// types of the modbus rtu slave serial front end
// assumes mrsl_defs.svh for all numeric constants
package mrsl_pkg;

    // ======================================================================
    // state machines, one-hot
    typedef enum logic [1:0] {
        MRSL_RX_IDLE = 2'h1,
        MRSL_RX_RUN  = 2'h2
    } mrsl_rx_t;

    typedef enum logic [1:0] {
        MRSL_TX_IDLE = 2'h1,
        MRSL_TX_RUN  = 2'h2
    } mrsl_tx_t;

    // ======================================================================
    // whole state of the link block
    typedef struct packed {
        logic [2:0]  rs_s;
        logic [2:0]  ua_s;
        logic [2:0]  jp_s;
        logic        rs_lv;
        logic        ua_lv;
        logic        jp_lv;
        logic [15:0] setup;
        logic [7:0]  station;
        logic [15:0] pend;
        logic        pend_v;
        mrsl_rx_t    rx_st;
        logic [12:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [9:0]  rx_sh;
        logic [12:0] gap_cnt;
        logic [5:0]  gap_bits;
        logic        frame_new;
        logic        accept;
        logic        bcast;
        logic        fwd;
        mrsl_tx_t    tx_st;
        logic [12:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [10:0] tx_sh;
        logic [27:0] rst_cnt;
        logic        restored;
        logic        rs485_tx;
        logic        rs485_de;
        logic        uart_tx;
        logic        rx_valid;
        logic        rx_sof;
        logic        rx_perr;
        logic [7:0]  rx_data;
        logic        tx_ready;
    } mrsl_state_t;

endpackage

// *** testbench/mrsl_master_model.sv ***
// master model: sends query bytes on the rs485 or uart line, reads replies
// assumes the bench calls its tasks and that both ends use the same settings
`timescale 1ns/1ps

module mrsl_master_model
#(
    parameter int DIV = 434
)
(
    input  wire logic clk_in,
    input  wire logic rs485_tx_in,
    input  wire logic rs485_de_in,
    output logic      rs485_line_out,
    output logic      uart_line_out
);
    // ======================================================================
    // idle lines rest high, as the line biasing would hold them
    initial
    begin
        rs485_line_out = 1'b1;
        uart_line_out  = 1'b1;
    end

    // ======================================================================
    // one character, lsb first, even parity unless told to spoil it
    task automatic send_byte(input logic [7:0] b, input logic on_uart, input logic bad,
                             output logic ok);
        logic [10:0] fr;
        int          n;
        fr = {1'b1, (^b) ^ bad, b, 1'b0}; // same speed and parity as device
        n  = 0;
        // wait up to 100000 cycles while the device drives its reply
        while (rs485_de_in === 1'b1 && n < 100000)
        begin
            @(posedge clk_in);
            n++;
        end
        ok = (n < 100000);  // a line held by the device counts against the run
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk_in);
            if (on_uart)
                uart_line_out <= fr[i];
            else
                rs485_line_out <= fr[i];
            repeat (DIV - 1) @(posedge clk_in);
        end
    endtask

    // ======================================================================
    // sample a reply at mid-bit; a slow driver still lands inside each bit
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        logic [9:0] fr;
        int         n;
        n = 0;
        while (!(rs485_de_in === 1'b1 && rs485_tx_in === 1'b0) && n < 20000)
        begin
            @(posedge clk_in);
            n++;
        end
        repeat (DIV / 2) @(posedge clk_in);
        ok = (n < 20000) && (rs485_tx_in === 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            repeat (DIV) @(posedge clk_in);
            fr[i] = rs485_tx_in;
        end
        b  = fr[7:0];
        ok = ok && (fr[8] === ^fr[7:0]) && (fr[9] === 1'b1);
    endtask
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench of the serial front end with a master model
// assumes the design's restore count is shortened to keep the run brief
`timescale 1ns/1ps
`include "mrsl_defs.svh"

module tb_top;
    localparam int DIV = int'(`MRSL_DIV_115200);
    localparam int RCYC = 100;

    logic        clk, rst, rs_rx, ua_rx, jumper, setup_wr, station_wr, tx_valid;
    logic [15:0] setup_data, setup;
    logic [7:0]  station_data, tx_data, rx_data, station, last_data;
    logic        tx_ready, rs_tx, de, ua_tx, rx_valid, rx_sof, rx_perr, last_sof;
    logic        chk_rs, chk_ua;
    logic [4:0]  rs_h = 5'h1f;
    logic [4:0]  ua_h = 5'h1f;
    int          failures, num_checks, n_valid, n_perr, n_de;

    mrsl_link #(.RESTORE_CYC(RCYC)) mrsl_link_inst (
        .clk_in(clk), .sys_rst_in(rst), .rs485_rx_in(rs_rx), .uart_rx_in(ua_rx),
        .factory_restore_in(jumper), .setup_wr_in(setup_wr), .setup_data_in(setup_data),
        .station_wr_in(station_wr), .station_data_in(station_data), .tx_valid_in(tx_valid),
        .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rs485_tx_out(rs_tx),
        .rs485_de_out(de), .uart_tx_out(ua_tx), .rx_valid_out(rx_valid), .rx_sof_out(rx_sof),
        .rx_perr_out(rx_perr), .rx_data_out(rx_data), .setup_out(setup), .station_out(station));

    mrsl_master_model #(.DIV(DIV)) mrsl_master_model_inst (
        .clk_in(clk), .rs485_tx_in(rs_tx), .rs485_de_in(de),
        .rs485_line_out(rs_rx), .uart_line_out(ua_rx));

    // ======================================================================
    // 50 mhz clock
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ======================================================================
    // report a mismatch at once, count every compare
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ======================================================================
    // pulse counters and mirror checks; only stable stretches are compared
    // so a one-cycle latency slip does not swamp the log
    always @(posedge clk)
    begin
        if (rx_valid === 1'b1)
        begin
            n_valid++;
            last_sof  = rx_sof;
            last_data = rx_data;
        end
        if (rx_perr === 1'b1) n_perr++;
        if (de === 1'b1) n_de++;
        if (chk_rs && rs_h[2] === rs_h[3] && rs_h[3] === rs_h[4])
            check(ua_tx, rs_h[3], "uart_mirror");
        if (chk_ua && ua_h[2] === ua_h[3] && ua_h[3] === ua_h[4])
            check(rs_tx, ua_h[3], "rs485_mirror");
        rs_h <= {rs_h[3:0], rs_rx};
        ua_h <= {ua_h[3:0], ua_rx};
    end

    // ======================================================================
    // bus helpers
    task automatic wait_ready();
        int n;
        n = 0;
        while (tx_ready !== 1'b1 && n < 150000)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 150000)
        begin
            failures++;
            $display("[ERR] tx_ready wait ran out");
            summarize();
        end
    endtask

    task automatic offer(input logic [7:0] b);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data  <= b;
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    task automatic query(input logic [7:0] a, input logic bad, output int dv, output int dp);
        int   v0, p0;
        logic ok;
        wait_ready();
        v0 = n_valid;
        p0 = n_perr;
        mrsl_master_model_inst.send_byte(a, 1'b0, bad, ok);
        check(ok, 1'b1, "line_free");
        repeat (DIV / 4) @(posedge clk);
        dv = n_valid - v0;
        dp = n_perr - p0;
    endtask

    // reply offered after a silent frame must never reach the line
    task automatic dropped_reply();
        int d0;
        wait_ready();
        d0 = n_de;
        offer(8'ha5);
        // a taken byte raises the driver on the very next cycle
        repeat (DIV * 2) @(posedge clk);
        check(16'(n_de - d0), 16'h0000, "de_cycles");
        check(tx_ready, 1'b1, "tx_ready_after_drop");
    endtask

    // ======================================================================
    // scenarios
    // the write is parked one cycle before it lands on an idle link
    task automatic t_setup();
        logic [15:0] val [2] = '{16'h0003, 16'h000c};
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            setup_wr   <= 1'b1;
            setup_data <= val[i];
            @(posedge clk);
            setup_wr <= 1'b0;
            @(posedge clk);
            #1 check(setup, val[i], "setup_write");
        end
    endtask

    task automatic t_station();
        logic [7:0] wr [4] = '{8'h00, 8'hf8, 8'hf7, 8'h05};
        logic [7:0] ex [4] = '{8'h01, 8'h01, 8'hf7, 8'h05};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            station_wr   <= 1'b1;
            station_data <= wr[i];
            @(posedge clk);
            station_wr <= 1'b0;
            #1 check(station, ex[i], "station_write");
        end
    endtask

    task automatic t_frames();
        int         dv, dp;
        logic [7:0] b;
        logic       ok;
        query(8'h09, 1'b1, dv, dp);
        check(16'(dv), 16'h0000, "foreign_valid");
        check(16'(dp), 16'h0001, "foreign_perr");
        dropped_reply();
        query(8'h00, 1'b0, dv, dp);
        check(16'(dv), 16'h0001, "bcast_valid");
        check({last_sof, last_data}, 9'h100, "bcast_sof_data");
        dropped_reply();
        query(8'h05, 1'b0, dv, dp);
        check({last_sof, last_data}, 9'h105, "own_sof_data");
        wait_ready();
        chk_rs = 1'b0;
        fork
            offer(8'h3c);
            mrsl_master_model_inst.recv_byte(b, ok);
        join
        check(b, 8'h3c, "reply_data");
        check(ok, 1'b1, "reply_frame_8e1");
        repeat (DIV) @(posedge clk);
        check(de, 1'b0, "de_after_reply");
        chk_rs = 1'b1;
    endtask

    task automatic t_uart();
        logic ok;
        wait_ready();
        chk_ua = 1'b1;
        fork
            mrsl_master_model_inst.send_byte(8'h5a, 1'b1, 1'b0, ok);
            begin
                repeat (DIV / 2 + 8) @(posedge clk);
                check(de, 1'b1, "de_forwarding");
            end
        join
        check(ok, 1'b1, "uart_line_free");
        repeat (8) @(posedge clk);
        chk_ua = 1'b0;
    endtask

    task automatic t_restore();
        @(posedge clk);
        jumper <= 1'b1;
        repeat (RCYC / 2) @(posedge clk);
        check(station, 8'h05, "restore_early");
        repeat (RCYC) @(posedge clk);
        #1 check(station, 8'h01, "restore_station");
        check(setup, 16'h0009, "restore_setup");
        jumper <= 1'b0;
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        rst <= 1'b1;
        jumper <= 1'b0;
        setup_wr <= 1'b0;
        setup_data <= 16'h0000;
        station_wr <= 1'b0;
        station_data <= 8'h00;
        tx_valid <= 1'b0;
        tx_data <= 8'h00;
        chk_rs = 1'b0;
        chk_ua = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 check(setup, 16'h0009, "reset_setup");
        check({station, de, rs_tx, ua_tx, tx_ready}, 12'h016, "reset_outputs");
        chk_rs = 1'b1;
        t_setup();
        t_station();
        t_frames();
        t_uart();
        t_restore();
        summarize();
    end
endmodule
